// ### rhts_sensor.sv
`timescale 1ns/100ps
`default_nettype none
`include "rhts_defines.svh"
// Summary of operation
// - sda falling while scl high starts frame
// - sda rising while scl high ends frame
// - header is address 0x40 plus direction bit
// - ack each good byte on ninth clock
// - decode hold and polled trigger commands
// - hold mode stretches scl until conversion done
// - polled read header nacked until done
// - result bit 1 marks humidity, bit 0 zero
// - master nack then stop skips checksum
// - repeated start begins new header anytime
// - soft reset restores defaults, heater kept, 15ms
// - bits 7 and 0 select result widths
// - low supply flag updated after each conversion
// - bit 2 enables heater, default off
// - reload defaults per trigger when bit 1 clear
// - checksum byte follows read data
// - checksum init zero, no final xor
// - result sent msb first, two bytes
// - 15ms idle wait after power up
module rhts_sensor #(
  parameter int RESET_CYCLES = `RHTS_RESET_CYCLES,
  parameter int CONV_UNIT = `RHTS_CONV_UNIT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic linkClk,
  input wire logic sclIn,
  output var logic sclOut,
  output var logic sclOe,
  input wire logic sdaIn,
  output var logic sdaOut,
  output var logic sdaOe,
  input wire rhts_pkg::rhts_raw_t rawData,
  input wire logic lowSupply,
  output var logic convBusy,
  output var logic heaterEn
);
  import rhts_pkg::*;

  localparam int CW = `RHTS_CNT_W;
  localparam logic [CW-1:0] RST_LOAD = CW'(RESET_CYCLES);
  localparam logic [7:0] CFG_DEF = `RHTS_CFG_RESET;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic rhts_bits_t res_bits(input logic hum, input logic [1:0] sel);
    case (sel)
      2'h0: res_bits = hum ? `RHTS_HUM_R0 : `RHTS_TEMP_R0;
      2'h1: res_bits = hum ? `RHTS_HUM_R1 : `RHTS_TEMP_R1;
      2'h2: res_bits = hum ? `RHTS_HUM_R2 : `RHTS_TEMP_R2;
      default: res_bits = hum ? `RHTS_HUM_R3 : `RHTS_TEMP_R3;
    endcase
  endfunction

  function automatic logic [15:0] fmt_word(input rhts_raw_t raw, input rhts_bits_t bits,
                                           input logic hum);
    logic [15:0] mask;
    mask = ~(16'hffff >> bits);
    fmt_word = ({raw, 2'h0} & mask) | (16'({hum, 1'b0}));
  endfunction

  // ----------------------------------------
  // link and system clock domain signals
  // ----------------------------------------
  rhts_state_t state;
  rhts_kind_t kind;
  logic [2:0] sclSync, sdaSync, doneSync;
  logic [1:0] busySync;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg, userReg, txByte;
  logic [15:0] result;
  logic [1:0] txIdx, lastIdx;
  logic sclS, sdaS, startCond, stopCond, sclRise, sclFall, doneEvt, busy;
  logic byteEnd, ackExit, readStart, addrHit, hdrRead, isConvCmd, knownCmd, rxAck;
  logic cmdEnd, srCmd, convCmd, wrEnd, isTxData, txLoad, txShift, txBit;
  logic convPending, holdMode, convHumReq, convTgl, srTgl, readSel;
  rhts_crc_if crcIf ();
  logic [2:0] convSync, srSync;
  logic [CW-1:0] sampleCnt, resetCnt, convLen;
  logic [15:0] resWord;
  logic convEvt, srEvt, convDone, sampleHum, lowFlag, doneTgl, resetBusy;
  rhts_bits_t sampleBits, reqBits;

  // ----------------------------------------
  // pin and clock-crossing synchronisers
  // ----------------------------------------
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      doneSync <= 3'h0;
      busySync <= 2'h3;
    end else begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
      doneSync <= {doneSync[1:0], doneTgl};
      busySync <= {busySync[0], resetBusy};
    end
  end

  // ----------------------------------------
  // line events and decode
  // ----------------------------------------
  assign sclS = sclSync[1];
  assign sdaS = sdaSync[1];
  assign busy = busySync[1];
  assign doneEvt = doneSync[1] ^ doneSync[2];
  assign startCond = sclS & sclSync[2] & sdaSync[2] & ~sdaS;
  assign stopCond = sclS & sclSync[2] & ~sdaSync[2] & sdaS;
  assign sclRise = sclS & ~sclSync[2];
  assign sclFall = ~sclS & sclSync[2];
  assign byteEnd = (state == ST_RX) & sclFall & (bitCnt == 4'h8);
  assign ackExit = (state == ST_RXACK) & sclFall;
  assign hdrRead = shiftReg[0];
  assign readStart = ackExit & (kind == KIND_HDR) & hdrRead;
  assign addrHit = shiftReg[7:1] == `RHTS_DEV_ADDR;
  assign isConvCmd = (shiftReg == `RHTS_CMD_TEMP_HOLD) | (shiftReg == `RHTS_CMD_HUM_HOLD)
                   | (shiftReg == `RHTS_CMD_TEMP_POLL) | (shiftReg == `RHTS_CMD_HUM_POLL);
  assign knownCmd = isConvCmd | (shiftReg == `RHTS_CMD_WR_CFG)
                  | (shiftReg == `RHTS_CMD_RD_CFG) | (shiftReg == `RHTS_CMD_SRESET);
  assign rxAck = (kind == KIND_HDR) ? (addrHit & ~busy & ~(hdrRead & convPending & ~holdMode))
               : (kind == KIND_CMD) ? knownCmd : 1'b1;
  assign cmdEnd = byteEnd & rxAck & (kind == KIND_CMD);
  assign srCmd = cmdEnd & (shiftReg == `RHTS_CMD_SRESET);
  assign convCmd = cmdEnd & isConvCmd;
  assign wrEnd = byteEnd & (kind == KIND_WDAT);

  // ----------------------------------------
  // transmit selection and checksum feed
  // ----------------------------------------
  assign lastIdx = readSel ? 2'h2 : 2'h1;
  assign isTxData = txIdx != lastIdx;
  assign txByte = (txIdx == 2'h0) ? (readSel ? result[15:8] : userReg)
                : (readSel && txIdx == 2'h1) ? result[7:0] : crcIf.crc;
  assign txLoad = (readStart & ~convPending) | ((state == ST_STRETCH) & ~convPending)
                | ((state == ST_TXACK) & sclFall);
  assign txShift = (state == ST_TX) & sclFall & (bitCnt != 4'h8);
  assign txBit = txLoad ? txByte[7] : shiftReg[6];
  assign crcIf.clear = byteEnd & (kind == KIND_HDR);
  assign crcIf.shift = (txLoad | txShift) & isTxData;
  assign crcIf.din = txBit;

  rhts_crc8 u_crc (
    .linkClk(linkClk),
    .rst_b(rst_b),
    .crcPort(crcIf)
  );

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      kind <= KIND_HDR;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      txIdx <= 2'h0;
    end else if (startCond) begin
      state <= ST_RX;
      kind <= KIND_HDR;
      bitCnt <= 4'h0;
    end else if (stopCond) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_RX: begin
          if (sclRise) begin
            shiftReg <= {shiftReg[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
          end
          if (byteEnd) begin
            state <= rxAck ? ST_RXACK : ST_IDLE;
            txIdx <= 2'h0;
          end
        end
        ST_RXACK: begin
          if (readStart) begin
            state <= convPending ? ST_STRETCH : ST_TX;
          end else if (ackExit) begin
            state <= ST_RX;
            bitCnt <= 4'h0;
            kind <= (kind == KIND_CMD && shiftReg == `RHTS_CMD_WR_CFG) ? KIND_WDAT : KIND_CMD;
          end
        end
        ST_STRETCH: begin
          if (!convPending) begin
            state <= ST_TX;
          end
        end
        ST_TX: begin
          if (sclFall && bitCnt == 4'h8) begin
            state <= ST_TXACK;
          end else if (txShift) begin
            shiftReg <= {shiftReg[6:0], 1'b0};
            bitCnt <= bitCnt + 4'h1;
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            if (sdaS || txIdx == lastIdx) begin
              state <= ST_IDLE;
            end else begin
              txIdx <= txIdx + 2'h1;
            end
          end else if (sclFall) begin
            state <= ST_TX;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (txLoad) begin
        shiftReg <= txByte;
        bitCnt <= 4'h1;
      end
    end
  end

  // ----------------------------------------
  // open-drain drivers
  // ----------------------------------------
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      if (startCond || stopCond) begin
        sdaOe <= 1'b0;
      end else if (byteEnd) begin
        sdaOe <= rxAck;
      end else if (txLoad || txShift) begin
        sdaOe <= ~txBit;
      end else if (ackExit || ((state == ST_TX) && sclFall)) begin
        sdaOe <= 1'b0;
      end
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      sclOe <= 1'b0;
      sclOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      if (readStart) begin
        sclOe <= convPending;
      end else if (!convPending) begin
        sclOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // command effects
  // ----------------------------------------
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      convPending <= 1'b0;
      holdMode <= 1'b0;
      convHumReq <= 1'b0;
      convTgl <= 1'b0;
      srTgl <= 1'b0;
      readSel <= 1'b0;
    end else begin
      if (convCmd) begin
        convPending <= 1'b1;
        holdMode <= ~shiftReg[`RHTS_CMD_POLL_BIT];
        convHumReq <= shiftReg[`RHTS_CMD_HUM_BIT];
        convTgl <= ~convTgl;
        readSel <= 1'b1;
      end else if (srCmd) begin
        convPending <= 1'b0;
        srTgl <= ~srTgl;
      end else if (doneEvt) begin
        convPending <= 1'b0;
      end
      if (cmdEnd && shiftReg == `RHTS_CMD_RD_CFG) begin
        readSel <= 1'b0;
      end
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 16'h0000;
      userReg <= CFG_DEF;
      heaterEn <= 1'b0;
    end else begin
      heaterEn <= userReg[`RHTS_CFG_HEATER];
      if (srCmd || (convCmd && !userReg[`RHTS_CFG_NORELOAD])) begin
        userReg <= (CFG_DEF & ~`RHTS_HEAT_MASK) | (userReg & `RHTS_HEAT_MASK);
      end else if (wrEnd) begin
        userReg <= (shiftReg & ~`RHTS_LOWSUP_MASK) | (userReg & `RHTS_LOWSUP_MASK);
      end
      // supply flag update wins over a write in the same cycle
      if (doneEvt) begin
        result <= resWord;
        userReg[`RHTS_CFG_LOWSUP] <= lowFlag;
      end
    end
  end

  // ----------------------------------------
  // conversion engine, system clock
  // ----------------------------------------
  assign convEvt = convSync[1] ^ convSync[2];
  assign srEvt = srSync[1] ^ srSync[2];
  assign reqBits = res_bits(convHumReq, {userReg[`RHTS_CFG_RES_HI], userReg[`RHTS_CFG_RES_LO]});
  assign convLen = CW'(reqBits * CONV_UNIT);
  assign convDone = (sampleCnt == CW'(1)) & ~srEvt & ~convEvt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convSync <= 3'h0;
      srSync <= 3'h0;
    end else begin
      convSync <= {convSync[1:0], convTgl};
      srSync <= {srSync[1:0], srTgl};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetCnt <= RST_LOAD;
      resetBusy <= 1'b1;
    end else begin
      resetBusy <= srEvt | (resetCnt > CW'(1));
      if (srEvt) begin
        resetCnt <= RST_LOAD;
      end else if (resetCnt != '0) begin
        resetCnt <= resetCnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sampleCnt <= '0;
      sampleHum <= 1'b0;
      sampleBits <= 4'h0;
      convBusy <= 1'b0;
      resWord <= 16'h0000;
      lowFlag <= 1'b0;
      doneTgl <= 1'b0;
    end else if (srEvt) begin
      sampleCnt <= '0;
      convBusy <= 1'b0;
    end else if (convEvt) begin
      sampleCnt <= convLen;
      sampleHum <= convHumReq;
      sampleBits <= reqBits;
      convBusy <= 1'b1;
    end else if (convDone) begin
      sampleCnt <= '0;
      convBusy <= 1'b0;
      resWord <= fmt_word(rawData, sampleBits, sampleHum);
      lowFlag <= lowSupply;
      doneTgl <= ~doneTgl;
    end else if (sampleCnt != '0) begin
      sampleCnt <= sampleCnt - CW'(1);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_hdr_read_busy;
    byteEnd && kind == KIND_HDR && addrHit && hdrRead && convPending && !holdMode;
  endsequence

  sequence s_stretch_release;
    state == ST_STRETCH && !convPending;
  endsequence

  a_start_frame: assert property (@(posedge linkClk) disable iff (!rst_b)
    startCond |=> state == ST_RX && bitCnt == 4'h0 && kind == KIND_HDR)
    else $error("start not taken");
  a_stop_frame: assert property (@(posedge linkClk) disable iff (!rst_b)
    stopCond |=> state == ST_IDLE ##1 !sdaOe)
    else $error("stop not taken");
  a_addr_ack: assert property (@(posedge linkClk) disable iff (!rst_b)
    byteEnd && kind == KIND_HDR && !addrHit |=> !sdaOe && state == ST_IDLE)
    else $error("foreign address acked");
  a_poll_nack: assert property (@(posedge linkClk) disable iff (!rst_b)
    s_hdr_read_busy |=> !sdaOe && state == ST_IDLE)
    else $error("poll acked while busy");
  a_stretch_end: assert property (@(posedge linkClk) disable iff (!rst_b)
    s_stretch_release |=> !sclOe && state == ST_TX)
    else $error("stretch not released");
  a_stretch_hold: assert property (@(posedge linkClk) disable iff (!rst_b)
    state == ST_STRETCH && convPending |-> sclOe)
    else $error("scl not held");
  a_nack_ends: assert property (@(posedge linkClk) disable iff (!rst_b)
    state == ST_TXACK && sclRise && sdaS && !startCond && !stopCond |=> state == ST_IDLE)
    else $error("nack ignored");
  a_heater_kept: assert property (@(posedge linkClk) disable iff (!rst_b)
    srCmd |=> userReg[`RHTS_CFG_HEATER] == $past(userReg[`RHTS_CFG_HEATER])
              && userReg[`RHTS_CFG_NORELOAD])
    else $error("soft reset lost heater");
  a_crc_clear: assert property (@(posedge linkClk) disable iff (!rst_b)
    crcIf.clear |=> crcIf.crc == 8'h00)
    else $error("checksum not cleared");
  a_status_bits: assert property (@(posedge clk) disable iff (!rst_b)
    convDone |=> resWord[`RHTS_STAT_TYPE] == sampleHum && !resWord[0] && $changed(doneTgl))
    else $error("status bits wrong");
  a_res_width: assert property (@(posedge clk) disable iff (!rst_b)
    convDone && sampleBits == 4'h8 |=> resWord[7:2] == 6'h00)
    else $error("resolution mask wrong");
  a_reset_busy: assert property (@(posedge clk) disable iff (!rst_b)
    srEvt |=> resetBusy && resetCnt == RST_LOAD)
    else $error("soft reset not busy");
endmodule // rhts_sensor
`default_nettype wire

// ### rhts_defines.svh
`ifndef RHTS_DEFINES_SVH
`define RHTS_DEFINES_SVH

// ----------------------------------------
// bus address and command codes
// ----------------------------------------
`define RHTS_DEV_ADDR 7'h40
`define RHTS_CMD_TEMP_HOLD 8'he3
`define RHTS_CMD_HUM_HOLD 8'he5
`define RHTS_CMD_TEMP_POLL 8'hf3
`define RHTS_CMD_HUM_POLL 8'hf5
`define RHTS_CMD_WR_CFG 8'he6
`define RHTS_CMD_RD_CFG 8'he7
`define RHTS_CMD_SRESET 8'hfe
`define RHTS_CMD_POLL_BIT 4
`define RHTS_CMD_HUM_BIT 2

// ----------------------------------------
// config/status register layout
// ----------------------------------------
`define RHTS_CFG_RESET 8'h02
`define RHTS_CFG_RES_HI 7
`define RHTS_CFG_LOWSUP 6
`define RHTS_CFG_HEATER 2
`define RHTS_CFG_NORELOAD 1
`define RHTS_CFG_RES_LO 0
`define RHTS_HEAT_MASK 8'h04
`define RHTS_LOWSUP_MASK 8'h40

// ----------------------------------------
// result word and checksum
// ----------------------------------------
`define RHTS_STAT_TYPE 1
`define RHTS_CRC_POLY 8'h31
`define RHTS_CRC_INIT 8'h00

// ----------------------------------------
// resolution table, bits per result
// ----------------------------------------
`define RHTS_HUM_R0 4'hc
`define RHTS_HUM_R1 4'h8
`define RHTS_HUM_R2 4'ha
`define RHTS_HUM_R3 4'hb
`define RHTS_TEMP_R0 4'he
`define RHTS_TEMP_R1 4'hc
`define RHTS_TEMP_R2 4'hd
`define RHTS_TEMP_R3 4'hb

// ----------------------------------------
// timing
// ----------------------------------------
`define RHTS_CLK_KHZ 10000
`define RHTS_RESET_MS 15
`define RHTS_RESET_CYCLES (`RHTS_RESET_MS * `RHTS_CLK_KHZ)
`define RHTS_CONV_UNIT 500
`define RHTS_CNT_W 20

`endif

// ### rhts_pkg.sv
package rhts_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK, ST_STRETCH} rhts_state_t;
  typedef enum logic [1:0] {KIND_HDR, KIND_CMD, KIND_WDAT} rhts_kind_t;
  typedef logic [13:0] rhts_raw_t;
  typedef logic [3:0] rhts_bits_t;
endpackage

// ### rhts_crc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rhts_crc_if;
  logic clear;
  logic shift;
  logic din;
  logic [7:0] crc;
  modport engine (input clear, input shift, input din, output crc);
  modport user (output clear, output shift, output din, input crc);
endinterface
`default_nettype wire

// ### rhts_crc8.sv
`timescale 1ns/100ps
`default_nettype none
`include "rhts_defines.svh"
module rhts_crc8 (
  input wire logic linkClk,
  input wire logic rst_b,
  rhts_crc_if.engine crcPort
);
  import rhts_pkg::*;

  // ----------------------------------------
  // serial checksum, msb first
  // ----------------------------------------
  logic fb;
  logic [7:0] next_crc;
  assign fb = crcPort.din ^ crcPort.crc[7];
  assign next_crc = {crcPort.crc[6:0], 1'b0} ^ (fb ? `RHTS_CRC_POLY : 8'h00);

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      crcPort.crc <= `RHTS_CRC_INIT;
    end else if (crcPort.clear) begin
      crcPort.crc <= `RHTS_CRC_INIT;
    end else if (crcPort.shift) begin
      crcPort.crc <= next_crc;
    end
  end
endmodule // rhts_crc8
`default_nettype wire

// ### rhts_host.sv
`timescale 1ns/100ps
`default_nettype none
module rhts_host (
  input wire logic clk,
  input wire logic sclLine,
  input wire logic sdaLine,
  output var logic sclM,
  output var logic sdaM
);
  int stretch = 0;
  initial begin
    sclM = 1'b1;
    sdaM = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic start();
    sdaM = 1'b1;
    tick(2);
    sclM = 1'b1;
    tick(4);
    sdaM = 1'b0;
    tick(4);
    sclM = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sdaM = 1'b0;
    tick(2);
    sclM = 1'b1;
    tick(4);
    sdaM = 1'b1;
    tick(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sdaM = b;
    tick(2);
    sclM = 1'b1;
    tick(1);
    while (!sclLine && stretch < 20000) begin
      tick(1);
      stretch++;
    end
    tick(1);
    r = sdaLine;
    tick(2);
    sclM = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ackOut, ack);
  endtask
endmodule // rhts_host
`default_nettype wire

// ### rhts_sensor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rhts_sensor_bench;
  import rhts_pkg::*;
  localparam int RST_CYC = 200;
  localparam int UNIT = 40;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b = 1'b0;
  logic lowSupply = 1'b0;
  rhts_raw_t rawData = '0;
  logic sclOut, sclOe, sdaOut, sdaOe, convBusy, heaterEn, sclM, sdaM;
  wire sclLine = (sclOe ? sclOut : 1'b1) & sclM;
  wire sdaLine = (sdaOe ? sdaOut : 1'b1) & sdaM;
  logic [31:0] seed = 32'h07df;
  logic [7:0] cfg = 8'h02;
  int errorCnt = 0;
  int checked = 0;
  int cyc = 0;
  int humW[4] = '{12, 8, 10, 11};
  int tmpW[4] = '{14, 12, 13, 11};
  logic [7:0] cmds[4] = '{8'he3, 8'he5, 8'hf3, 8'hf5};
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #32 linkClk = ~linkClk;
  end
  rhts_sensor #(.RESET_CYCLES(RST_CYC), .CONV_UNIT(UNIT)) i_rhts_sensor (
    .clk(clk), .rst_b(rst_b), .linkClk(linkClk), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .rawData(rawData),
    .lowSupply(lowSupply), .convBusy(convBusy), .heaterEn(heaterEn)
  );
  rhts_host host (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine), .sclM(sclM), .sdaM(sdaM));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d, input int nb);
    logic [7:0] c;
    c = 8'h00;
    for (int i = nb * 8 - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic ok);
    logic [7:0] q;
    logic a;
    host.xfer(b, 1'b1, q, a);
    check("ack", 16'(a), 16'(!ok));
  endtask
  task automatic frame(input logic [7:0] cmd, input logic ok);
    host.start();
    send(8'h80, 1'b1);
    send(cmd, ok);
  endtask
  task automatic readCfg();
    logic [7:0] v, c;
    logic a;
    frame(8'he7, 1'b1);
    host.start();
    send(8'h81, 1'b1);
    host.xfer(8'hff, 1'b0, v, a);
    host.xfer(8'hff, 1'b1, c, a);
    host.stop();
    check("cfg", 16'(v), 16'(cfg));
    check("cfgcrc", 16'(c), 16'(crc8(16'(cfg), 1)));
    check("heater", 16'(heaterEn), 16'(cfg[2]));
  endtask
  task automatic writeCfg(input logic [7:0] v);
    frame(8'he6, 1'b1);
    send(v | 8'h40, 1'b1);
    host.stop();
    cfg = (v & 8'hbf) | (cfg & 8'h40);
  endtask
  task automatic measure(input logic [7:0] cmd);
    logic hum, poll, a;
    logic [7:0] m, l, c, q;
    logic [15:0] e;
    int w, n;
    hum = cmd[2];
    poll = cmd[4];
    rawData = rhts_raw_t'(rnd());
    lowSupply = ^rawData[3:0];
    if (!cfg[1])
      cfg = 8'h02 | (cfg & 8'h04);
    w = hum ? humW[{cfg[7], cfg[0]}] : tmpW[{cfg[7], cfg[0]}];
    e = ({rawData, 2'b00} & ~(16'hffff >> w)) | {14'h0, hum, 1'b0};
    host.stretch = 0;
    frame(cmd, 1'b1);
    if (poll) begin
      host.stop();
      check("busy", 16'(convBusy), 16'h1);
      n = 0;
      do begin
        host.start();
        host.xfer(8'h81, 1'b1, q, a);
        if (a)
          host.stop();
        n++;
      end while (a && n < 200);
      check("pollnack", 16'(n > 1), 16'h1);
    end else begin
      host.start();
      send(8'h81, 1'b1);
    end
    host.xfer(8'hff, 1'b0, m, a);
    host.xfer(8'hff, poll, l, a);
    if (!poll)
      host.xfer(8'hff, 1'b1, c, a);
    host.stop();
    cfg[6] = lowSupply;
    check("result", {m, l}, e);
    if (poll)
      check("idle", 16'(sdaOe), 16'h0);
    else
      check("crc", 16'(c), 16'(crc8(e, 2)));
    check("stretch", 16'(host.stretch > 0), 16'(!poll));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errorCnt++;
      endOfTest();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #2;
    rst_b = 1'b1;
    host.start();
    send(8'h80, 1'b0);
    host.stop();
    host.tick(RST_CYC);
    readCfg();
    host.start();
    send(8'h82, 1'b0);
    host.stop();
    frame(8'h55, 1'b0);
    host.stop();
    $display("test reset and refusals done");
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        writeCfg((cfg & 8'h7e) | {r[1], 6'h00, r[0]});
        measure(cmds[k]);
        readCfg();
      end
    end
    $display("test measurements done");
    writeCfg((cfg & 8'h3a) | 8'h85);
    readCfg();
    frame(8'hfe, 1'b1);
    host.stop();
    cfg = 8'h02 | (cfg & 8'h04);
    host.start();
    send(8'h80, 1'b0);
    host.stop();
    host.tick(RST_CYC);
    readCfg();
    $display("test soft reset done");
    writeCfg((cfg & 8'h3c) | 8'h01);
    readCfg();
    measure(8'he3);
    readCfg();
    $display("test reload done");
    endOfTest();
  end
endmodule // rhts_sensor_bench
`default_nettype wire
